// File: sic_top.sv
/*
  Standby (halt/stop) sequencer, oscillator gating and interrupt request/mask flags behind an APB slave.
  Assumes the CPU core, peripherals and oscillators sit outside; pclk is the always-on clock.
*/
// Design decisions made here: the register offsets and register access over APB.
`include "sic_regs.svh"
module sic_top #(
  parameter int SETTLE_BASE_LOG2 = `SIC_SETTLE_BASE_LOG2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SIC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`SIC_NUM_EXT-1:0] ext_irq_pin,
  input wire logic [`SIC_NUM_SRC-`SIC_NUM_EXT-1:0] periph_irq,
  input wire logic irq_take,
  input wire logic [2:0] irq_take_id,
  input wire logic lso_sw_stoppable,
  input wire logic xtal_mode,
  output logic irq_ack_req,
  output logic [2:0] irq_ack_id,
  output logic cpu_run,
  output logic sys_clk_run,
  output logic main_osc_run,
  output logic lso_run,
  output logic standby_irq
);
  localparam int NS = `SIC_NUM_SRC;
  localparam int NE = `SIC_NUM_EXT;

  logic [NS-1:0] irq_request_flags;
  logic [NS-1:0] irq_mask_flags;
  logic [7:0] ext_irq_edge_mode_reg;
  logic low_speed_osc_stop_bit;
  logic [`SIC_SEL_W-1:0] osc_settle_time_select;
  logic [`SIC_EV_W-1:0] int_status;
  logic [`SIC_EV_W-1:0] int_mask;
  logic [NE-1:0] ext_s1, ext_s2, ext_s3;
  logic opt_s1, opt_s2, xtal_s1, xtal_s2;
  sic_pkg::sic_state_e state, next_state;
  sic_settle_if sif ();

  // apb decode
  wire logic setup = psel && !penable;
  wire logic wr = psel && penable && pready && pwrite;
  wire logic hit_req = paddr == `SIC_OFS_REQ;
  wire logic hit_mask = paddr == `SIC_OFS_MASK;
  wire logic hit_edge = paddr == `SIC_OFS_EDGE;
  wire logic hit_ctrl = paddr == `SIC_OFS_CTRL;
  wire logic hit_settle = paddr == `SIC_OFS_SETTLE;
  wire logic hit_stat = paddr == `SIC_OFS_STAT;
  wire logic hit_istat = paddr == `SIC_OFS_ISTAT;
  wire logic hit_imask = paddr == `SIC_OFS_IMASK;
  wire logic mapped = hit_req || hit_mask || hit_edge || hit_ctrl || hit_settle || hit_stat || hit_istat || hit_imask;
  wire logic flag_access = psel && (hit_req || hit_mask);

  // external edge detection, pins synchronised first
  wire logic [NE-1:0] ext_rise = ext_s2 & ~ext_s3;
  wire logic [NE-1:0] ext_fall = ~ext_s2 & ext_s3;
  logic [NE-1:0] ext_evt;
  always_comb begin
    for (int i = 0; i < NE; i++) begin
      ext_evt[i] = (ext_rise[i] && ext_irq_edge_mode_reg[2 + 2 * i]) ||
                   (ext_fall[i] && ext_irq_edge_mode_reg[3 + 2 * i]);
    end
  end
  wire logic [NS-1:0] src_set = {periph_irq, ext_evt};
  wire logic [NS-1:0] take_clr = irq_take ? (NS'(1) << irq_take_id) : '0;
  wire logic [NS-1:0] sw_clr = (wr && hit_req) ? ~pwdata[NS-1:0] : '0;
  // set beats both clears so an event on the clearing edge survives
  wire logic [NS-1:0] next_req = (irq_request_flags & ~(take_clr | sw_clr)) | src_set;
  wire logic [NS-1:0] pending = irq_request_flags & ~irq_mask_flags;
  wire logic wake = |pending;

  // lowest index wins; in-service state is not consulted, so nesting is free
  logic [2:0] pend_id;
  always_comb begin
    pend_id = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pend_id = 3'(i);
      end
    end
  end

  // standby sequencer
  wire logic cmd_halt = wr && hit_ctrl && pwdata[`SIC_CTRL_HALT];
  wire logic cmd_stop = wr && hit_ctrl && pwdata[`SIC_CTRL_STOP];
  always_comb begin
    next_state = state;
    case (state)
      sic_pkg::SIC_RUN: begin
        if (cmd_stop) begin
          next_state = sic_pkg::SIC_STOP;
        end else if (cmd_halt) begin
          next_state = sic_pkg::SIC_HALT;
        end
      end
      sic_pkg::SIC_HALT: begin
        if (wake) begin
          next_state = sic_pkg::SIC_RUN;
        end
      end
      sic_pkg::SIC_STOP: begin
        if (wake) begin
          next_state = xtal_s2 ? sic_pkg::SIC_SETTLE : sic_pkg::SIC_RUN;
        end
      end
      sic_pkg::SIC_SETTLE: begin
        if (sif.done) begin
          next_state = sic_pkg::SIC_RUN;
        end
      end
      default: next_state = sic_pkg::SIC_RUN;
    endcase
  end
  assign sif.start = (state == sic_pkg::SIC_STOP) && (next_state == sic_pkg::SIC_SETTLE);
  assign sif.sel = osc_settle_time_select;
  wire logic left_standby = (state != sic_pkg::SIC_RUN) && (next_state == sic_pkg::SIC_RUN);
  wire logic [`SIC_EV_W-1:0] ev_set = {sif.done, left_standby};
  wire logic [`SIC_EV_W-1:0] ev_clr = (wr && hit_istat) ? pwdata[`SIC_EV_W-1:0] : '0;
  wire logic [`SIC_EV_W-1:0] next_int_status = (int_status & ~ev_clr) | ev_set;
  // option must allow it, else the stop bit is ignored
  wire logic lso_stop_req = low_speed_osc_stop_bit && opt_s2;

  wire logic [31:0] rd_mux =
    hit_req ? 32'(irq_request_flags) :
    hit_mask ? 32'(irq_mask_flags) :
    hit_edge ? 32'(ext_irq_edge_mode_reg) :
    hit_ctrl ? 32'({low_speed_osc_stop_bit, 2'b00}) :
    hit_settle ? 32'(osc_settle_time_select) :
    hit_stat ? 32'({lso_run, xtal_s2, opt_s2, state}) :
    hit_istat ? 32'(int_status) :
    hit_imask ? 32'(int_mask) : 32'h0000_0000;

  sic_settle_cnt #(.BASE_LOG2(SETTLE_BASE_LOG2)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif.cnt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_s1, ext_s2, ext_s3} <= '0;
      {opt_s1, opt_s2, xtal_s1, xtal_s2} <= 4'h0;
    end else begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      opt_s1 <= lso_sw_stoppable;
      opt_s2 <= opt_s1;
      xtal_s1 <= xtal_mode;
      xtal_s2 <= xtal_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_flags <= '0;
      irq_mask_flags <= `SIC_MASK_RST;
      ext_irq_edge_mode_reg <= 8'h00;
      low_speed_osc_stop_bit <= 1'b0;
      osc_settle_time_select <= `SIC_SEL_RST;
      int_status <= '0;
      int_mask <= '0;
    end else begin
      irq_request_flags <= next_req;
      int_status <= next_int_status;
      if (wr && hit_mask) irq_mask_flags <= pwdata[NS-1:0];
      // unused edge bits are kept zero whatever software writes
      if (wr && hit_edge) ext_irq_edge_mode_reg <= pwdata[7:0] & `SIC_EDGE_USED;
      if (wr && hit_ctrl) low_speed_osc_stop_bit <= pwdata[`SIC_CTRL_LSO_STOP];
      if (wr && hit_settle) osc_settle_time_select <= pwdata[`SIC_SEL_W-1:0];
      if (wr && hit_imask) int_mask <= pwdata[`SIC_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sic_pkg::SIC_RUN;
      irq_ack_req <= 1'b0;
      irq_ack_id <= 3'h0;
      cpu_run <= 1'b1;
      sys_clk_run <= 1'b1;
      main_osc_run <= 1'b1;
      lso_run <= 1'b1;
      standby_irq <= 1'b0;
    end else begin
      state <= next_state;
      irq_ack_req <= wake && !flag_access;
      irq_ack_id <= pend_id;
      cpu_run <= next_state == sic_pkg::SIC_RUN;
      sys_clk_run <= next_state != sic_pkg::SIC_STOP && next_state != sic_pkg::SIC_SETTLE;
      main_osc_run <= next_state != sic_pkg::SIC_STOP;
      lso_run <= !lso_stop_req;
      standby_irq <= |(next_int_status & int_mask);
    end
  end

  a_ack_defer: assert property (@(posedge pclk) disable iff (!presetn)
    flag_access |=> !irq_ack_req) else $error("ack during flag access");
  a_ack_nested: assert property (@(posedge pclk) disable iff (!presetn)
    wake && !flag_access |=> irq_ack_req && irq_ack_id == $past(pend_id)) else $error("ack missing");
  a_lso_option: assert property (@(posedge pclk) disable iff (!presetn)
    !opt_s2 |=> lso_run) else $error("lso stopped without option");
  a_lso_in_stop: assert property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_STOP && lso_run && !lso_stop_req |=> lso_run) else $error("lso lost in stop");
  a_halt_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_HALT && wake |=> state == sic_pkg::SIC_RUN ##0 cpu_run) else $error("halt kept");
  a_stop_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_STOP && wake |=> state != sic_pkg::SIC_STOP) else $error("stop kept");
  a_settle_wait: assert property (@(posedge pclk) disable iff (!presetn)
    sif.start |=> (state == sic_pkg::SIC_SETTLE && !cpu_run) [*8]) else $error("settle cut short");
  a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_STOP |-> !sys_clk_run && !cpu_run && !main_osc_run) else $error("clock in stop");
  a_halt_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_HALT |-> sys_clk_run && !cpu_run) else $error("halt clocks wrong");
  a_edge_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_irq_edge_mode_reg & ~`SIC_EDGE_USED) == 8'h00) else $error("edge spare bits set");
  c_halt_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state == sic_pkg::SIC_HALT ##1 state == sic_pkg::SIC_RUN);
  c_stop_settle: cover property (@(posedge pclk) disable iff (!presetn) sif.done);
  c_ack_deferred: cover property (@(posedge pclk) disable iff (!presetn) wake && flag_access);
endmodule : sic_top

// File: sic_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the standby and interrupt control block.
  Assumes a 32-bit APB slave decoding word-aligned byte addresses.
*/
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH

`define SIC_ADDR_W 8
`define SIC_OFS_REQ 8'h00
`define SIC_OFS_MASK 8'h04
`define SIC_OFS_EDGE 8'h08
`define SIC_OFS_CTRL 8'h0C
`define SIC_OFS_SETTLE 8'h10
`define SIC_OFS_STAT 8'h14
`define SIC_OFS_ISTAT 8'h18
`define SIC_OFS_IMASK 8'h1C

`define SIC_NUM_SRC 8
`define SIC_NUM_EXT 2
`define SIC_MASK_RST 8'hFF
`define SIC_EDGE_USED 8'h3C
`define SIC_CTRL_HALT 0
`define SIC_CTRL_STOP 1
`define SIC_CTRL_LSO_STOP 2
`define SIC_SEL_W 3
`define SIC_SEL_RST 3'h4
`define SIC_SEL_MAX 3'h4
`define SIC_SETTLE_BASE_LOG2 10
`define SIC_CNT_W 16
`define SIC_EV_WAKE 0
`define SIC_EV_SETTLED 1
`define SIC_EV_W 2

`endif

// File: sic_pkg.sv
/*
  Types shared by the standby and interrupt control block.
  Assumes sic_regs.svh for all numeric constants.
*/
package sic_pkg;
  typedef enum logic [1:0] {
    SIC_RUN,
    SIC_HALT,
    SIC_STOP,
    SIC_SETTLE
  } sic_state_e;
endpackage : sic_pkg

// File: sic_settle_if.sv
/*
  Carrier between the standby sequencer and its oscillation settle counter.
  Assumes both ends run on pclk.
*/
`include "sic_regs.svh"
interface sic_settle_if;
  logic start;
  logic [`SIC_SEL_W-1:0] sel;
  logic done;
  modport ctl (output start, output sel, input done);
  modport cnt (input start, input sel, output done);
endinterface : sic_settle_if

// File: sic_settle_cnt.sv
/*
  Oscillation settle wait counter: a start pulse loads 2**(BASE_LOG2+sel) cycles, sel capped at SIC_SEL_MAX, done pulses at the end.
  Assumes start comes from logic on pclk and sel is stable while counting.
*/
`include "sic_regs.svh"
module sic_settle_cnt #(
  parameter int BASE_LOG2 = `SIC_SETTLE_BASE_LOG2
) (
  input wire logic pclk,
  input wire logic presetn,
  sic_settle_if.cnt sif
);
  logic [`SIC_CNT_W-1:0] count;
  logic busy;
  wire logic [`SIC_CNT_W-1:0] load_val;
  wire logic last;

  // selectors above the maximum saturate, so the wait never wraps to something short
  assign load_val = `SIC_CNT_W'(1) << (BASE_LOG2 + int'((sif.sel > `SIC_SEL_MAX) ? `SIC_SEL_MAX : sif.sel));
  assign last = busy && (count == `SIC_CNT_W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      busy <= 1'b0;
      sif.done <= 1'b0;
    end else begin
      sif.done <= last;
      if (sif.start) begin
        count <= load_val;
        busy <= 1'b1;
      end else if (busy) begin
        count <= count - `SIC_CNT_W'(1);
        busy <= !last;
      end
    end
  end

  a_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
    sif.start |=> busy && count == $past(load_val)) else $error("settle count not loaded");
endmodule : sic_settle_cnt

// File: standby_interrupt_control_tb.sv
/*
  Self-checking bench for sic_top: APB register tasks, interrupt flag, acknowledge and standby sequences.
  Assumes sic_regs.svh, sic_pkg and sic_settle_if/sic_settle_cnt are compiled first; pclk 25 MHz.
*/
`include "sic_regs.svh"
module standby_interrupt_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`SIC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [`SIC_NUM_EXT-1:0] ext_irq_pin;
  logic [`SIC_NUM_SRC-`SIC_NUM_EXT-1:0] periph_irq;
  logic irq_take, lso_sw_stoppable, xtal_mode, irq_ack_req, cpu_run, sys_clk_run, main_osc_run, lso_run, standby_irq;
  logic [2:0] irq_take_id, irq_ack_id;
  logic ack_in_access, err_seen;
  int n_errors, samples_checked, n;

  sic_top #(.SETTLE_BASE_LOG2(BASE)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .periph_irq(periph_irq), .irq_take(irq_take), .irq_take_id(irq_take_id),
    .lso_sw_stoppable(lso_sw_stoppable), .xtal_mode(xtal_mode), .irq_ack_req(irq_ack_req),
    .irq_ack_id(irq_ack_id), .cpu_run(cpu_run), .sys_clk_run(sys_clk_run), .main_osc_run(main_osc_run),
    .lso_run(lso_run), .standby_irq(standby_irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // access-phase sample of irq_ack_req kept for the deferral check
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1);
    // slave answers in the first access cycle, no wait states
    chk(32'(i), 32'h1);
    ack_in_access = irq_ack_req;
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task take(input logic [2:0] id);
    @(posedge pclk);
    irq_take <= 1'b1;
    irq_take_id <= id;
    @(posedge pclk);
    irq_take <= 1'b0;
  endtask : take

  task pulse(input logic [5:0] v);
    @(posedge pclk);
    periph_irq <= v;
    @(posedge pclk);
    periph_irq <= 6'h00;
  endtask : pulse

  // bounded wait, n ends as the count of edges seen
  task wait_cpu;
    n = 0;
    while (cpu_run !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_cpu

  function automatic logic [31:0] outs();
    return {28'h0, cpu_run, sys_clk_run, main_osc_run, lso_run};
  endfunction : outs

  task end_of_test;
    $display("n_errors=%0d samples_checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // whole sequence needs about 200 cycles
  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, irq_take, irq_take_id} = '0;
    {ext_irq_pin, periph_irq, lso_sw_stoppable} = '0;
    xtal_mode = 1'b1;
    presetn = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    chk(outs(), 32'hF);
    rdchk(`SIC_OFS_MASK, 32'hFF);
    rdchk(`SIC_OFS_SETTLE, 32'h4);
    rdchk(`SIC_OFS_REQ, 32'h0);
    wr(`SIC_OFS_EDGE, 32'hFF);
    rdchk(`SIC_OFS_EDGE, 32'h3C);
    wr(`SIC_OFS_EDGE, 32'h04);
    wr(`SIC_OFS_REQ, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    chk(32'(err_seen), 32'h1);
    chk(rd, 32'h0);
    // two requests at once, lower index wins
    wr(`SIC_OFS_MASK, 32'hF3);
    pulse(6'h03);
    cyc(3);
    chk({28'h0, irq_ack_req, irq_ack_id}, 32'hA);
    rdchk(`SIC_OFS_REQ, 32'h0C);
    chk(32'(ack_in_access), 32'h0);
    wr(`SIC_OFS_MASK, 32'hF3);
    chk(32'(ack_in_access), 32'h0);
    cyc(3);
    chk(32'(irq_ack_req), 32'h1);
    take(3'd2);
    cyc(2);
    chk({28'h0, irq_ack_req, irq_ack_id}, 32'hB);
    // halt with a request already pending leaves at once
    wr(`SIC_OFS_CTRL, 32'h1);
    cyc(3);
    chk(32'(cpu_run), 32'h1);
    rdchk(`SIC_OFS_STAT, 32'h18);
    take(3'd3);
    wr(`SIC_OFS_REQ, 32'h0);
    wr(`SIC_OFS_ISTAT, 32'h3);
    // halt, woken by a rising edge on pin 0
    wr(`SIC_OFS_MASK, 32'hFE);
    wr(`SIC_OFS_CTRL, 32'h1);
    cyc(2);
    chk(outs(), 32'h7);
    rdchk(`SIC_OFS_STAT, 32'h19);
    @(posedge pclk);
    ext_irq_pin <= 2'b01;
    wait_cpu;
    chk(32'(n < 10), 32'h1);
    cyc(1);
    chk({28'h0, irq_ack_req, irq_ack_id}, 32'h8);
    take(3'd0);
    wr(`SIC_OFS_MASK, 32'hFB);
    wr(`SIC_OFS_REQ, 32'h0);
    // stop bit honoured only with the option set
    wr(`SIC_OFS_CTRL, 32'h4);
    cyc(4);
    chk(32'(lso_run), 32'h1);
    lso_sw_stoppable <= 1'b1;
    cyc(4);
    chk(32'(lso_run), 32'h0);
    wr(`SIC_OFS_CTRL, 32'h0);
    cyc(2);
    chk(32'(lso_run), 32'h1);
    // stop with crystal settle; peripherals idle beforehand
    wr(`SIC_OFS_SETTLE, 32'h7);
    // register keeps the raw selector; only the counter saturates it
    rdchk(`SIC_OFS_SETTLE, 32'h7);
    wr(`SIC_OFS_SETTLE, 32'h0);
    wr(`SIC_OFS_ISTAT, 32'h3);
    wr(`SIC_OFS_CTRL, 32'h2);
    cyc(2);
    chk(outs(), 32'h1);
    pulse(6'h01);
    n = 0;
    while (main_osc_run !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk({30'h0, sys_clk_run, cpu_run}, 32'h0);
    wait_cpu;
    // 2**(BASE+0) cycles plus a couple of hand-off edges
    chk(32'(n >= (1 << BASE) && n <= (1 << BASE) + 3), 32'h1);
    rdchk(`SIC_OFS_ISTAT, 32'h3);
    wr(`SIC_OFS_IMASK, 32'h1);
    cyc(2);
    chk(32'(standby_irq), 32'h1);
    wr(`SIC_OFS_ISTAT, 32'h1);
    cyc(2);
    chk(32'(standby_irq), 32'h0);
    rdchk(`SIC_OFS_ISTAT, 32'h2);
    // no crystal: release skips the settle wait
    wr(`SIC_OFS_REQ, 32'h0);
    xtal_mode <= 1'b0;
    wr(`SIC_OFS_SETTLE, 32'h4);
    wr(`SIC_OFS_CTRL, 32'h2);
    cyc(2);
    chk(32'(cpu_run), 32'h0);
    pulse(6'h01);
    wait_cpu;
    chk(32'(n < 8), 32'h1);
    end_of_test;
  end
endmodule : standby_interrupt_control_tb
